// ### rtl/ua_regs_defines.vh
// Constants for the two-channel serial port register block
// What this block does
// - Offset 0x00 read gives buffer, write loads hold
// - Hold and receive buffer are eight bits
// - Two identical channels at two fixed bases
// - Enable register holds six source enables
// - Disabled sources never signal an interrupt
// - Identity register read-only, resets to 0x01
// - Pending bit is low while interrupt pending
// - Only highest priority pending source is reported, but shift empty with DMA transmit done share one code
// - Line error, receive, hold empty, shift empty, then DMA
// - Line error code clears on status read
// - Receive code clears on buffer or identity read
// - Hold empty clears on hold write, identity read
// - Shift empty flag bit 3, same clears
// - DMA done codes clear on identity read
// - Baud divisor register, 16 bits, reset zero
// - Baud fraction register, reset zero
// - Frame gap delay register, reset zero
`ifndef UA_REGS_DEFINES_VH
`define UA_REGS_DEFINES_VH

// ****************************************
// Channel pages (bases 0x4000_8000, 0x4000_8100)
// ****************************************
`define UA_CH0_PAGE      24'h400080
`define UA_CH1_PAGE      24'h400081

// ****************************************
// Register offsets
// ****************************************
`define UA_OFF_DATA      8'h00
`define UA_OFF_IEN       8'h04
`define UA_OFF_IID       8'h08
`define UA_OFF_LCTL      8'h0C
`define UA_OFF_DCTL      8'h10
`define UA_OFF_LSTAT     8'h14
`define UA_OFF_RSVD      8'h18
`define UA_OFF_SCRATCH   8'h1C
`define UA_OFF_BDIV      8'h20
`define UA_OFF_BFRAC     8'h24
`define UA_OFF_GAP       8'h30

// ****************************************
// Reset values
// ****************************************
`define UA_RST_BYTE      8'h00
`define UA_RST_DIV       16'h0000
`define UA_RST_IID       8'h01

// ****************************************
// Source bit positions (enable and flag layout)
// ****************************************
`define UA_SRC_RX        0
`define UA_SRC_HOLD      1
`define UA_SRC_LINE      2
`define UA_SRC_SHIFT     3
`define UA_SRC_DMARX     4
`define UA_SRC_DMATX     5
`define UA_SRC_W         6

// ****************************************
// Identity codes, bits 4..0
// ****************************************
`define UA_ID_NONE       5'h01
`define UA_ID_LINE       5'h06
`define UA_ID_RX         5'h04
`define UA_ID_HOLD       5'h02
`define UA_ID_SHIFT      5'h10
`define UA_ID_DMARX      5'h0C
`define UA_ID_DMATX      5'h0A
`define UA_ID_SHIFTDMA   5'h1A

`endif

// ### rtl/ua_int_prio.v
// Interrupt source priority encoder for one channel
`timescale 1ns/100ps
`include "ua_regs_defines.vh"

module ua_int_prio (
    // Enabled pending sources
    input  wire [5:0] srcAct,
    // Identity code and sources an identity read clears
    output reg  [4:0] idCode,
    output reg  [5:0] idSrc
);

    always @* begin
        idCode = `UA_ID_NONE;
        idSrc  = 6'h00;
        if (srcAct[`UA_SRC_LINE]) begin
            idCode = `UA_ID_LINE;
            // Left set: only a line status read clears it
            idSrc  = 6'h00;
        end else if (srcAct[`UA_SRC_RX]) begin
            idCode = `UA_ID_RX;
            idSrc  = 6'h01;
        end else if (srcAct[`UA_SRC_HOLD]) begin
            idCode = `UA_ID_HOLD;
            idSrc  = 6'h02;
        end else if (srcAct[`UA_SRC_SHIFT] &&
                     srcAct[`UA_SRC_DMATX]) begin
            idCode = `UA_ID_SHIFTDMA;
            idSrc  = 6'h28;
        end else if (srcAct[`UA_SRC_SHIFT]) begin
            idCode = `UA_ID_SHIFT;
            idSrc  = 6'h08;
        end else if (srcAct[`UA_SRC_DMARX]) begin
            idCode = `UA_ID_DMARX;
            idSrc  = 6'h10;
        end else if (srcAct[`UA_SRC_DMATX]) begin
            idCode = `UA_ID_DMATX;
            idSrc  = 6'h20;
        end
    end

endmodule

// ### rtl/ua_regs_irq.v
// Two-channel serial port registers, APB slave, interrupt identity
`timescale 1ns/100ps
`include "ua_regs_defines.vh"

module ua_regs_irq (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // APB slave
    input  wire [31:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Serial engine events, one bit per channel; received byte and line status, eight bits per channel
    input  wire [1:0]  rxEvent,
    input  wire [15:0] rxByte,
    input  wire [1:0]  lineErrEvent,
    input  wire [1:0]  holdEmptyEvent,
    input  wire [1:0]  shiftEmptyEvent,
    input  wire [1:0]  dmaRxDoneEvent,
    input  wire [1:0]  dmaTxDoneEvent,
    input  wire [15:0] lineStatus,
    // Transmit hold and line status read pulse toward the serial engine
    output reg  [15:0] txHoldData,
    output reg  [1:0]  txHoldStrobe,
    output reg  [1:0]  lineStatusRead,
    // Configuration toward the serial engine
    output reg  [15:0] lineControl,
    output reg  [15:0] dataControl,
    output reg  [31:0] baudDivisor,
    output reg  [15:0] baudFraction,
    output reg  [15:0] frameGapDelay,
    // Interrupt requests
    output reg  [1:0]  irq
);

    // ****************************************
    // Storage
    // ****************************************
    reg  [7:0]  rxBuf_reg   [0:1];
    reg  [5:0]  ienable_reg [0:1];
    reg  [7:0]  scratch_reg [0:1];
    reg  [5:0]  flag_reg    [0:1];
    reg  [11:0] capClr_reg;
    reg  [11:0] clrMask;
    reg  [31:0] readMux;

    wire [11:0] setMask;
    wire [11:0] srcAct;
    wire [9:0]  idCode;
    wire [11:0] idSrc;

    integer ch;

    // ****************************************
    // Address decode
    // ****************************************
    wire [7:0] offs   = paddr[7:0];
    wire       chSel  = paddr[8];
    wire       pageOk = (paddr[31:8] == {`UA_CH0_PAGE}) ||
                        (paddr[31:8] == {`UA_CH1_PAGE});
    wire       accPh  = psel & penable;
    wire       start  = accPh & ~pready;
    wire       done   = accPh & pready;

    // Offset is mapped for the given direction
    function isMapped;
        input [7:0] o;
        input       wr;
        begin
            if (o == `UA_OFF_DATA || o == `UA_OFF_IEN ||
                o == `UA_OFF_LCTL || o == `UA_OFF_DCTL ||
                o == `UA_OFF_SCRATCH || o == `UA_OFF_BDIV ||
                o == `UA_OFF_BFRAC || o == `UA_OFF_GAP) begin
                isMapped = 1'b1;
            end else if (o == `UA_OFF_IID ||
                         o == `UA_OFF_LSTAT ||
                         o == `UA_OFF_RSVD) begin
                // Read-only and reserved words ignore writes
                isMapped = 1'b1;
            end else begin
                isMapped = 1'b0;
            end
            isMapped = isMapped & ~wr | isMapped & wr;
        end
    endfunction

    wire hitOk = pageOk & (paddr[1:0] == 2'b00) & isMapped(offs, pwrite);

    // ****************************************
    // Event sources and identity per channel
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gCh
            assign setMask[g*6 +: 6] = {dmaTxDoneEvent[g],
                                        dmaRxDoneEvent[g],
                                        shiftEmptyEvent[g],
                                        lineErrEvent[g],
                                        holdEmptyEvent[g],
                                        rxEvent[g]};
            // Flags stay stored; enable only gates reporting
            assign srcAct[g*6 +: 6] = flag_reg[g] &
                                      ienable_reg[g];
            ua_int_prio uPrio (
                .srcAct (srcAct[g*6 +: 6]),
                .idCode (idCode[g*5 +: 5]),
                .idSrc  (idSrc[g*6 +: 6])
            );
        end
    endgenerate

    // ****************************************
    // Read data selection
    // ****************************************
    always @* begin
        readMux = 32'h0000_0000;
        if (offs == `UA_OFF_DATA) begin
            readMux[7:0] = rxBuf_reg[chSel];
        end else if (offs == `UA_OFF_IEN) begin
            readMux[5:0] = ienable_reg[chSel];
        end else if (offs == `UA_OFF_IID) begin
            readMux[4:0] = idCode[chSel*5 +: 5];
        end else if (offs == `UA_OFF_LCTL) begin
            readMux[7:0] = lineControl[chSel*8 +: 8];
        end else if (offs == `UA_OFF_DCTL) begin
            readMux[7:0] = dataControl[chSel*8 +: 8];
        end else if (offs == `UA_OFF_LSTAT) begin
            readMux[7:0] = lineStatus[chSel*8 +: 8];
        end else if (offs == `UA_OFF_SCRATCH) begin
            readMux[7:0] = scratch_reg[chSel];
        end else if (offs == `UA_OFF_BDIV) begin
            readMux[15:0] = baudDivisor[chSel*16 +: 16];
        end else if (offs == `UA_OFF_BFRAC) begin
            readMux[7:0] = baudFraction[chSel*8 +: 8];
        end else if (offs == `UA_OFF_GAP) begin
            readMux[7:0] = frameGapDelay[chSel*8 +: 8];
        end
    end

    // ****************************************
    // Flag clear masks from completed accesses
    // ****************************************
    always @* begin
        clrMask = 12'h000;
        if (done && hitOk && !pwrite) begin
            if (offs == `UA_OFF_DATA) begin
                clrMask[chSel*6 + `UA_SRC_RX] = 1'b1;
            end else if (offs == `UA_OFF_LSTAT) begin
                clrMask[chSel*6 + `UA_SRC_LINE] = 1'b1;
            end else if (offs == `UA_OFF_IID) begin
                // Only the sources that were reported
                clrMask = capClr_reg;
            end
        end else if (done && hitOk && pwrite &&
                     offs == `UA_OFF_DATA) begin
            clrMask[chSel*6 + `UA_SRC_HOLD]  = 1'b1;
            clrMask[chSel*6 + `UA_SRC_SHIFT] = 1'b1;
        end
    end

    // ****************************************
    // APB handshake: one wait state per access
    // ****************************************
    always @(posedge clk) begin
        if (!rst_b) begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            capClr_reg <= 12'h000;
        end else if (start) begin
            pready     <= 1'b1;
            pslverr    <= ~hitOk;
            prdata     <= (hitOk && !pwrite) ? readMux : 32'h0000_0000;
            capClr_reg <= 12'h000;
            if (hitOk && !pwrite && offs == `UA_OFF_IID) begin
                capClr_reg[chSel*6 +: 6] <= idSrc[chSel*6 +: 6];
            end
        end else begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Register writes and flags
    // ****************************************
    always @(posedge clk) begin
        if (!rst_b) begin
            txHoldData     <= 16'h0000;
            txHoldStrobe   <= 2'b00;
            lineStatusRead <= 2'b00;
            lineControl    <= 16'h0000;
            dataControl    <= 16'h0000;
            baudDivisor    <= {`UA_RST_DIV, `UA_RST_DIV};
            baudFraction   <= 16'h0000;
            frameGapDelay  <= 16'h0000;
            irq            <= 2'b00;
            for (ch = 0; ch < 2; ch = ch + 1) begin
                rxBuf_reg[ch]   <= `UA_RST_BYTE;
                ienable_reg[ch] <= 6'h00;
                scratch_reg[ch] <= `UA_RST_BYTE;
                flag_reg[ch]    <= 6'h00;
            end
        end else begin
            txHoldStrobe   <= 2'b00;
            lineStatusRead <= 2'b00;
            for (ch = 0; ch < 2; ch = ch + 1) begin
                // A new event wins over a clear in the same cycle
                flag_reg[ch] <= (flag_reg[ch] & ~clrMask[ch*6 +: 6]) |
                                setMask[ch*6 +: 6];
                if (rxEvent[ch]) begin
                    rxBuf_reg[ch] <= rxByte[ch*8 +: 8];
                end
                // Pending indicator low means a request is up
                irq[ch] <= ~idCode[ch*5];
            end
            if (done && hitOk && !pwrite &&
                offs == `UA_OFF_LSTAT) begin
                lineStatusRead[chSel] <= 1'b1;
            end
            if (done && hitOk && pwrite) begin
                if (offs == `UA_OFF_DATA) begin
                    // Receive buffer is left untouched
                    txHoldData[chSel*8 +: 8] <= pwdata[7:0];
                    txHoldStrobe[chSel]      <= 1'b1;
                end else if (offs == `UA_OFF_IEN) begin
                    ienable_reg[chSel] <= pwdata[5:0];
                end else if (offs == `UA_OFF_LCTL) begin
                    lineControl[chSel*8 +: 8] <= pwdata[7:0];
                end else if (offs == `UA_OFF_DCTL) begin
                    dataControl[chSel*8 +: 8] <= pwdata[7:0];
                end else if (offs == `UA_OFF_SCRATCH) begin
                    scratch_reg[chSel] <= pwdata[7:0];
                end else if (offs == `UA_OFF_BDIV) begin
                    baudDivisor[chSel*16 +: 16] <= pwdata[15:0];
                end else if (offs == `UA_OFF_BFRAC) begin
                    baudFraction[chSel*8 +: 8] <= pwdata[7:0];
                end else if (offs == `UA_OFF_GAP) begin
                    frameGapDelay[chSel*8 +: 8] <= pwdata[7:0];
                end
            end
        end
    end

endmodule

// ### sim/ua_regs_irq_chk.sv
// Port-level checks on the serial register block
`timescale 1ns/100ps
module ua_regs_irq_chk (
    // Clock and reset
    input wire        clk,
    input wire        rst_b,
    // APB
    input wire [31:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Engine side
    input wire [15:0] txHoldData,
    input wire [1:0]  txHoldStrobe,
    input wire [1:0]  lineStatusRead,
    input wire [31:0] baudDivisor,
    input wire [15:0] baudFraction,
    input wire [15:0] frameGapDelay,
    input wire [1:0]  irq
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    idle_data_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("data or error outside an answer");
    error_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access returned data");
    hold_write_a: assert property (
        txHoldStrobe[0] |-> $past(pready && pwrite && paddr == 32'h40008000)
        && txHoldData[7:0] == $past(pwdata[7:0]))
        else $error("channel 0 hold strobe without its write");
    hold_second_a: assert property (
        txHoldStrobe[1] |-> $past(pready && pwrite && paddr == 32'h40008100)
        && txHoldData[15:8] == $past(pwdata[7:0]))
        else $error("channel 1 hold strobe without its write");
    status_read_a: assert property (
        lineStatusRead[0] |-> $past(pready && !pwrite
        && paddr == 32'h40008014))
        else $error("status read pulse without status read");
    irq_clear_a: assert property (
        $fell(irq[0]) || $fell(irq[1]) |-> $past(pready, 2))
        else $error("interrupt dropped without an access");
    reset_regs_a: assert property (disable iff (1'b0)
        !rst_b |=> baudDivisor == 32'h0 && baudFraction == 16'h0
        && frameGapDelay == 16'h0)
        else $error("timing registers not cleared by reset");
endmodule

// ### sim/ua_serial_model.sv
// Stand-in for the two serial engines: event pulses and line data
`timescale 1ns/100ps
module ua_serial_model (
    // Clock
    input  wire         clk,
    // Events and data toward the register block
    output logic [1:0]  rxEvent,
    output logic [15:0] rxByte,
    output logic [1:0]  lineErrEvent,
    output logic [1:0]  holdEmptyEvent,
    output logic [1:0]  shiftEmptyEvent,
    output logic [1:0]  dmaRxDoneEvent,
    output logic [1:0]  dmaTxDoneEvent,
    output logic [15:0] lineStatus
);
    // ****************************************
    // Event driver
    // ****************************************
    initial begin
        {rxEvent, lineErrEvent, holdEmptyEvent} = 6'h00;
        {shiftEmptyEvent, dmaRxDoneEvent, dmaTxDoneEvent} = 6'h00;
        rxByte = 16'h0000;
        lineStatus = 16'h0000;
    end
    // Mask bits follow the enable layout; static, one caller at a time
    task fire(input int ch, input logic [5:0] m, input logic [15:0] d);
        rxByte <= d;
        // Each engine owns its own status byte
        lineStatus[ch*8 +: 8] <= d[ch*8 +: 8];
        rxEvent[ch] <= m[0];
        holdEmptyEvent[ch] <= m[1];
        lineErrEvent[ch] <= m[2];
        shiftEmptyEvent[ch] <= m[3];
        dmaRxDoneEvent[ch] <= m[4];
        dmaTxDoneEvent[ch] <= m[5];
        @(posedge clk);
        // Stale byte must not look valid after the strobe
        rxByte <= ~d;
        {rxEvent, lineErrEvent, holdEmptyEvent} <= 6'h00;
        {shiftEmptyEvent, dmaRxDoneEvent, dmaTxDoneEvent} <= 6'h00;
        @(posedge clk);
    endtask
endmodule

// ### sim/tb_uart_regs_interrupt_id.sv
// Self-checking bench for the two-channel serial register block
`timescale 1ns/100ps
module tb_uart_regs_interrupt_id;
    // ****************************************
    // Signals and model state
    // ****************************************
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, baudDivisor, rd;
    logic [31:0] seed = 32'h56;
    logic [15:0] rxByte, lineStatus, txHoldData, lineControl, dataControl;
    logic [15:0] baudFraction, frameGapDelay, lsv;
    logic [1:0]  rxEvent, lineErrEvent, holdEmptyEvent, shiftEmptyEvent;
    logic [1:0]  dmaRxDoneEvent, dmaTxDoneEvent, txHoldStrobe;
    logic [1:0]  lineStatusRead, irq;
    logic [7:0]  rb [2];
    logic [7:0]  offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                              8'h18, 8'h1C, 8'h20, 8'h24, 8'h30};
    logic [31:0] bad [4] = '{32'h40008028, 32'h40008034, 32'h40008204,
                             32'h40008006};
    int          errors = 0, tests_run = 0, cyc = 0, flg [2], en [2];

    ua_regs_irq ua_regs_irq_i (.*);
    ua_serial_model ua_serial_model_i (.*);

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [4:0] eid(input int a);
        if (a[2]) return 5'h06;
        if (a[0]) return 5'h04;
        if (a[1]) return 5'h02;
        if (a[3] && a[5]) return 5'h1A;
        if (a[3]) return 5'h10;
        if (a[4]) return 5'h0C;
        if (a[5]) return 5'h0A;
        return 5'h01;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ev(input int ch, input logic [5:0] m);
        logic [31:0] d;
        d = rnd();
        ua_serial_model_i.fire(ch, m, d[15:0]);
        flg[ch] |= m;
        lsv = d[15:0];
        if (m[0]) rb[ch] = d[ch*8 +: 8];
    endtask
    // Identity read; the model drops only what was reported
    task automatic rid(input int ch);
        logic [4:0] e;
        e = eid(flg[ch] & en[ch]);
        apb(1'b0, 32'h40008008 + ch * 256, 32'h0);
        chk("identity", e, rd);
        case (e)
            5'h04: flg[ch] &= ~6'h01;
            5'h02: flg[ch] &= ~6'h02;
            5'h1A: flg[ch] &= ~6'h28;
            5'h10: flg[ch] &= ~6'h08;
            5'h0C: flg[ch] &= ~6'h10;
            5'h0A: flg[ch] &= ~6'h20;
            default: ;
        endcase
        @(posedge clk);
        chk("irq", eid(flg[ch] & en[ch]) != 5'h01, irq[ch]);
    endtask
    task automatic end_sim();
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [31:0] b, d, m;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int ch = 0; ch < 2; ch++) begin
            b = 32'h40008000 + ch * 256;
            foreach (offs[i]) begin
                apb(1'b0, b + offs[i], 32'h0);
                chk("reset", offs[i] == 8'h08, rd);
            end
            foreach (offs[i]) begin
                d = rnd();
                m = (offs[i] == 8'h20) ? 32'hFFFF : 32'hFF;
                if (offs[i] == 8'h04) m = 32'h3F;
                if (offs[i] inside {8'h00, 8'h08, 8'h14, 8'h18}) m = 0;
                apb(1'b1, b + offs[i], d);
                chk("write error", 1'b0, err);
                apb(1'b0, b + offs[i], 32'h0);
                chk("readback", (d & m) | (offs[i] == 8'h08), rd);
                if (offs[i] == 8'h20)
                    chk("divisor", d[15:0], baudDivisor[ch*16+:16]);
                if (offs[i] == 8'h24)
                    chk("fraction", d[7:0], baudFraction[ch*8+:8]);
                if (offs[i] == 8'h30)
                    chk("gap", d[7:0], frameGapDelay[ch*8+:8]);
                if (offs[i] == 8'h0C)
                    chk("line ctl", d[7:0], lineControl[ch*8+:8]);
                if (offs[i] == 8'h10)
                    chk("data ctl", d[7:0], dataControl[ch*8+:8]);
                if (offs[i] == 8'h00)
                    chk("hold data", d[7:0], txHoldData[ch*8+:8]);
            end
            apb(1'b1, b + 8'h04, 32'h0);
            en[ch] = 0;
            ev(ch, 6'h01);
            rid(ch);
            apb(1'b1, b + 8'h04, 32'h3F);
            en[ch] = 6'h3F;
            apb(1'b0, b, 32'h0);
            flg[ch] &= ~6'h01;
            chk("receive byte", rb[ch], rd);
            rid(ch);
            ev(ch, 6'h37);
            rid(ch);
            apb(1'b0, b + 8'h14, 32'h0);
            flg[ch] &= ~6'h04;
            chk("line status", lsv[ch*8 +: 8], rd);
            repeat (5) rid(ch);
            ev(ch, 6'h28);
            repeat (2) rid(ch);
            ev(ch, 6'h38);
            repeat (3) rid(ch);
            ev(ch, 6'h18);
            repeat (3) rid(ch);
            ev(ch, 6'h0A);
            apb(1'b1, b, rnd());
            flg[ch] &= ~6'h0A;
            rid(ch);
        end
        foreach (bad[i]) begin
            apb(1'b0, bad[i], 32'h0);
            chk("refused", 1'b1, err);
        end
        end_sim();
    end
endmodule

bind ua_regs_irq ua_regs_irq_chk ua_regs_irq_chk_i (.*);
